// *** hdl/sps_page_stack.sv ***
// sfr space decode, page selection and three-byte page stack
//
// Summary of operation
// - direct 0x80..0xFF goes to sfr space
// - nibble 0x0/0x8 addresses are bit-addressable
// - page number space spans 256 pages
// - only pages 0x0, 0xC, 0xF populated
// - stack: current top, middle, bottom bytes
// - entry pushes stack, loads source page
// - return pops stack; empty bottom gives zero
// - software stack writes never push or pop
// - middle and bottom writable during service
// - source page: 0x00, 0x0C or 0x10
// - auto enable clear stops paging and shifts
// - some registers decode on every page
// - push overwrites bottom byte always
// - page select writable in any cycle without a push or pop, takes effect next cycle
// - auto enable bit0 at 0x84, page 0x0F
// - page select at 0xA7, all pages
// - middle byte at 0x85, all pages
`default_nettype none
module sps_page_stack
  import sps_pkg::*;
(
  input wire logic i_mclk,          // core clock
  input wire logic i_rst,           // async reset, active high
  input wire logic i_acc,           // access strobe, one cycle
  input wire logic i_direct,        // direct addressing mode
  input wire logic i_wr,            // write when high, else read
  input wire logic i_bit_op,        // bit access instead of byte
  input wire logic [2:0] i_bit_sel, // bit position for bit access
  input wire logic [7:0] i_addr,    // access address
  input wire logic [7:0] i_wdata,   // write data or bit in [0]
  input wire logic [7:0] i_ext_rdata, // read data of other sfrs
  input wire logic i_ext_all_pages, // ext sfr decoded on all pages
  input wire logic i_irq_entry,     // vector entry pulse
  input wire logic [3:0] i_irq_src, // interrupting source code
  input wire logic i_irq_return,    // interrupt return pulse
  output logic o_sfr_sel,           // access goes to sfr space
  output logic o_ram_sel,           // access goes to data memory
  output logic o_bit_ok,            // bit access allowed here
  output logic o_ext_sel,           // access for other sfr, paged
  output logic [7:0] o_page,        // current page select
  output logic [7:0] o_stack_mid,   // middle stack byte
  output logic [7:0] o_stack_bot,   // bottom stack byte
  output logic o_auto_en,           // auto page enable
  output logic [7:0] o_rdata        // read data, registered
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] page;
    logic auto_en;
    logic [7:0] rdata;
  } sps_state_t;

  sps_state_t st_r;
  sps_state_t st_nxt;

  logic in_sfr;
  logic bit_ok;
  logic page_pop;
  logic hit_ctrl;
  logic hit_mid;
  logic hit_bot;
  logic hit_page;
  logic own_hit;
  logic push;
  logic pop;
  logic wr_acc;
  logic [7:0] entry_page;
  logic [7:0] cur_val;
  logic [7:0] new_val;
  logic [7:0] own_rd;
  logic [7:0] mid_q;
  logic [7:0] bot_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // sfr space only for direct accesses in the upper half
  assign in_sfr = i_direct && (i_addr >= SPS_SFR_LO)
                  && (i_addr <= SPS_SFR_HI);
  assign bit_ok = (i_addr[3:0] == SPS_BIT_NIB_A)
                  || (i_addr[3:0] == SPS_BIT_NIB_B);
  // a page is one of 256; only three are populated
  assign page_pop = (st_r.page == SPS_PAGE_0)
                    || (st_r.page == SPS_PAGE_C)
                    || (st_r.page == SPS_PAGE_F);
  assign hit_page = in_sfr && (i_addr == SPS_ADDR_PAGE);
  assign hit_mid = in_sfr && (i_addr == SPS_ADDR_MID);
  assign hit_bot = in_sfr && (i_addr == SPS_ADDR_BOT);
  assign hit_ctrl = in_sfr && (i_addr == SPS_ADDR_CTRL)
                    && (st_r.page == SPS_PAGE_CTRL);
  assign own_hit = hit_page || hit_mid || hit_bot || hit_ctrl;
  // other sfrs: all-page ones ignore page select
  assign o_ext_sel = in_sfr && !own_hit
                     && (i_ext_all_pages || page_pop);

  // only legal bit accesses modify state
  assign wr_acc = i_acc && i_wr && (!i_bit_op || bit_ok);

  // ---------------------------------------------------------------
  // entry page lookup
  // ---------------------------------------------------------------
  always_comb begin
    unique case (i_irq_src)
      SPS_SRC_BUS_CTRL: entry_page = SPS_PAGE_C;
      SPS_SRC_SERIAL2,
      SPS_SRC_COUNTER2,
      SPS_SRC_COMP3,
      SPS_SRC_TIMER4,
      SPS_SRC_TIMER5: entry_page = SPS_PAGE_X;
      default: entry_page = SPS_PAGE_0;
    endcase
  end

  // shifts only on interrupt events, gated by auto enable
  assign push = i_irq_entry && st_r.auto_en;
  assign pop = i_irq_return && !i_irq_entry
               && st_r.auto_en;

  // ---------------------------------------------------------------
  // read and bit merge
  // ---------------------------------------------------------------
  always_comb begin
    own_rd = SPS_READ_ZERO;
    if (hit_page) begin
      own_rd = st_r.page;
    end else if (hit_mid) begin
      own_rd = mid_q;
    end else if (hit_bot) begin
      own_rd = bot_q;
    end else if (hit_ctrl) begin
      own_rd[SPS_AUTO_EN_BIT] = st_r.auto_en;
    end
  end

  // bit writes patch one bit of the current value
  always_comb begin
    cur_val = own_rd;
    new_val = i_wdata;
    if (i_bit_op) begin
      new_val = cur_val;
      new_val[i_bit_sel] = i_wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.page = entry_page;
    end else if (pop) begin
      st_nxt.page = mid_q;
    end else if (wr_acc && hit_page) begin
      st_nxt.page = new_val;
    end
    if (wr_acc && hit_ctrl) begin
      st_nxt.auto_en = new_val[SPS_AUTO_EN_BIT];
    end
    if (i_acc && !i_wr) begin
      st_nxt.rdata = own_hit ? own_rd : i_ext_rdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{page: SPS_RST_PAGE, auto_en: SPS_RST_AUTO_EN,
                rdata: SPS_READ_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // middle and bottom stack bytes
  // ---------------------------------------------------------------
  sps_stack_byte #(
    .RST_VAL(SPS_RST_MID)
  ) u_mid (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_shift(push || pop),
    .i_shift_d(push ? st_r.page : bot_q),
    .i_wr(wr_acc && hit_mid),
    .i_wr_d(new_val),
    .o_q(mid_q)
  );

  sps_stack_byte #(
    .RST_VAL(SPS_RST_BOT)
  ) u_bot (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_shift(push || pop),
    .i_shift_d(push ? mid_q : SPS_READ_ZERO),
    .i_wr(wr_acc && hit_bot),
    .i_wr_d(new_val),
    .o_q(bot_q)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_sfr_sel = i_acc && in_sfr;
  assign o_ram_sel = i_acc && !in_sfr;
  assign o_bit_ok = bit_ok;
  assign o_page = st_r.page;
  assign o_stack_mid = mid_q;
  assign o_stack_bot = bot_q;
  assign o_auto_en = st_r.auto_en;
  assign o_rdata = st_r.rdata;
endmodule // sps_page_stack
`default_nettype wire

// *** include/sps_pkg.sv ***
// constants and types for the sfr page stack block
`default_nettype none
package sps_pkg;
  // ---------------------------------------------------------------
  // address space
  // ---------------------------------------------------------------
  localparam logic [7:0] SPS_SFR_LO = 8'h80;
  localparam logic [7:0] SPS_SFR_HI = 8'hFF;
  localparam logic [3:0] SPS_BIT_NIB_A = 4'h0;
  localparam logic [3:0] SPS_BIT_NIB_B = 4'h8;
  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SPS_ADDR_CTRL = 8'h84;
  localparam logic [7:0] SPS_ADDR_MID = 8'h85;
  localparam logic [7:0] SPS_ADDR_BOT = 8'h86;
  localparam logic [7:0] SPS_ADDR_PAGE = 8'hA7;
  // ---------------------------------------------------------------
  // pages
  // ---------------------------------------------------------------
  localparam logic [7:0] SPS_PAGE_0 = 8'h00;
  localparam logic [7:0] SPS_PAGE_C = 8'h0C;
  localparam logic [7:0] SPS_PAGE_F = 8'h0F;
  localparam logic [7:0] SPS_PAGE_X = 8'h10;
  localparam logic [7:0] SPS_PAGE_CTRL = 8'h0F;
  // ---------------------------------------------------------------
  // interrupt source codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SPS_SRC_BUS_CTRL = 4'h1;
  localparam logic [3:0] SPS_SRC_SERIAL2 = 4'h2;
  localparam logic [3:0] SPS_SRC_COUNTER2 = 4'h3;
  localparam logic [3:0] SPS_SRC_COMP3 = 4'h4;
  localparam logic [3:0] SPS_SRC_TIMER4 = 4'h5;
  localparam logic [3:0] SPS_SRC_TIMER5 = 4'h6;
  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] SPS_RST_PAGE = 8'h00;
  localparam logic [7:0] SPS_RST_MID = 8'h00;
  localparam logic [7:0] SPS_RST_BOT = 8'h00;
  localparam logic SPS_RST_AUTO_EN = 1'b1;
  localparam int SPS_AUTO_EN_BIT = 0;
  localparam logic [7:0] SPS_READ_ZERO = 8'h00;
endpackage : sps_pkg
`default_nettype wire

// *** hdl/sps_stack_byte.sv ***
// one stack byte: shift load has priority over software write
`default_nettype none
module sps_stack_byte
  import sps_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic i_mclk,        // core clock
  input wire logic i_rst,         // async reset, active high
  input wire logic i_shift,       // push or pop load
  input wire logic [7:0] i_shift_d, // value on shift
  input wire logic i_wr,          // software write strobe
  input wire logic [7:0] i_wr_d,  // software write value
  output logic [7:0] o_q          // stored byte
);
  typedef struct packed {
    logic [7:0] val;
  } sps_byte_t;

  sps_byte_t st_r;
  sps_byte_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_shift) begin
      st_nxt.val = i_shift_d;
    end else if (i_wr) begin
      st_nxt.val = i_wr_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{val: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.val;
endmodule // sps_stack_byte
`default_nettype wire

// *** testbench/sps_core_model.sv ***
// processor core model: direct and indirect accesses and interrupt events
`default_nettype none
module sps_core_model (
  input wire logic i_mclk,     // core clock
  output logic o_acc,          // access strobe
  output logic o_dir,          // direct addressing
  output logic o_wr,           // write when high
  output logic o_bo,           // bit access
  output logic [7:0] o_ad,     // address
  output logic [7:0] o_wd,     // write data
  output logic o_ent,          // vector entry pulse
  output logic [3:0] o_src,    // interrupt source
  output logic o_ret           // interrupt return pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {o_acc, o_dir, o_wr, o_bo, o_ent, o_ret} = 6'h00;
    {o_ad, o_wd, o_src} = 20'h0_0000;
  end
  // page is written before paged access, unpopulated pages used too
  task automatic put(input logic w, d, b, input logic [7:0] a, v);
    @(negedge i_mclk);
    {o_acc, o_wr, o_dir, o_bo} = {1'b1, w, d, b};
    {o_ad, o_wd} = {a, v};
  endtask
  // released lines show the inverse of the last value
  task automatic drop();
    @(negedge i_mclk);
    {o_acc, o_wr} = 2'h0;
    {o_ad, o_wd} = ~{o_ad, o_wd};
  endtask
  task automatic irq(input logic e, r, input logic [3:0] s);
    @(negedge i_mclk);
    {o_ent, o_ret, o_src} = {e, r, s};
    @(negedge i_mclk);
    {o_ent, o_ret, o_src} = {2'h0, ~s};
  endtask
endmodule // sps_core_model
`default_nettype wire

// *** testbench/sps_page_stack_sva.sv ***
// assertions on the sfr page stack ports
`default_nettype none
module sps_page_stack_sva
  import sps_pkg::*;
(
  input wire logic i_mclk, // core clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_acc, // access strobe
  input wire logic i_direct, // direct addressing
  input wire logic i_wr, // write when high
  input wire logic i_bit_op, // bit access
  input wire logic [7:0] i_addr, // access address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_irq_entry, // vector entry pulse
  input wire logic [3:0] i_irq_src, // interrupt source
  input wire logic i_irq_return, // interrupt return pulse
  input wire logic o_sfr_sel, // sfr space select
  input wire logic o_bit_ok, // bit access allowed
  input wire logic [7:0] o_page, // current page
  input wire logic [7:0] o_stack_mid, // middle stack byte
  input wire logic [7:0] o_stack_bot, // bottom stack byte
  input wire logic o_auto_en, // auto page enable
  input wire logic [7:0] o_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  logic dwr;
  logic [7:0] pg;
  assign dwr = i_acc && i_direct && i_wr && !i_bit_op
    && !(o_auto_en && (i_irq_entry || i_irq_return));
  assign pg = (i_irq_src == SPS_SRC_BUS_CTRL) ? SPS_PAGE_C
    : (i_irq_src >= SPS_SRC_SERIAL2 && i_irq_src <= SPS_SRC_TIMER5)
    ? SPS_PAGE_X : SPS_PAGE_0;
  sequence s_push;
    o_auto_en && i_irq_entry;
  endsequence
  sequence s_pop;
    o_auto_en && i_irq_return && !i_irq_entry;
  endsequence
  chk_sfr_decode: assert property (
    o_sfr_sel == (i_acc && i_direct && i_addr >= SPS_SFR_LO))
    else $error("sfr select wrong");
  chk_bit_nibble: assert property (
    o_bit_ok == (i_addr[2:0] == 3'h0)) else $error("bit access flag wrong");
  chk_entry_push: assert property (
    s_push |=> o_page == $past(pg) && o_stack_mid == $past(o_page)
    && o_stack_bot == $past(o_stack_mid)) else $error("push wrong");
  chk_return_pop: assert property (
    s_pop |=> o_stack_bot == 8'h00 && o_page == $past(o_stack_mid)
    && o_stack_mid == $past(o_stack_bot)) else $error("pop wrong");
  chk_auto_off: assert property (
    !o_auto_en && !i_acc && (i_irq_entry || i_irq_return)
    |=> $stable(o_page) && $stable(o_stack_mid) && $stable(o_stack_bot))
    else $error("stack shifted while auto paging off");
  chk_page_write: assert property (
    dwr && i_addr == SPS_ADDR_PAGE |=> o_page == $past(i_wdata))
    else $error("page write lost");
  chk_mid_only: assert property (
    dwr && i_addr == SPS_ADDR_MID |=> o_stack_mid == $past(i_wdata)
    && $stable(o_page) && $stable(o_stack_bot))
    else $error("middle write wrong");
  chk_bot_write: assert property (
    dwr && i_addr == SPS_ADDR_BOT |=> o_stack_bot == $past(i_wdata)
    && $stable(o_page) && $stable(o_stack_mid))
    else $error("bottom write wrong");
  chk_ctrl_lock: assert property (
    dwr && i_addr == SPS_ADDR_CTRL && o_page != SPS_PAGE_CTRL
    |=> $stable(o_auto_en)) else $error("control written off its page");
  chk_read_mid: assert property (
    i_acc && i_direct && !i_wr && i_addr == SPS_ADDR_MID
    |=> o_rdata == $past(o_stack_mid)) else $error("middle read wrong");
endmodule // sps_page_stack_sva
bind sps_page_stack sps_page_stack_sva u_sva (
  .i_mclk(i_mclk),
  .i_rst(i_rst),
  .i_acc(i_acc),
  .i_direct(i_direct),
  .i_wr(i_wr),
  .i_bit_op(i_bit_op),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_irq_entry(i_irq_entry),
  .i_irq_src(i_irq_src),
  .i_irq_return(i_irq_return),
  .o_sfr_sel(o_sfr_sel),
  .o_bit_ok(o_bit_ok),
  .o_page(o_page),
  .o_stack_mid(o_stack_mid),
  .o_stack_bot(o_stack_bot),
  .o_auto_en(o_auto_en),
  .o_rdata(o_rdata)
);
`default_nettype wire

// *** testbench/sps_page_stack_tb_top.sv ***
// self-checking bench for the sfr page stack
`default_nettype none
module sps_page_stack_tb_top
  import sps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_acc, i_direct, i_wr, i_bit_op, i_irq_entry, i_irq_return;
  logic i_ext_all_pages = 1'b0;
  logic [2:0] i_bit_sel = 3'h3;
  logic [3:0] i_irq_src;
  logic [7:0] i_addr, i_wdata, o_page, o_stack_mid, o_stack_bot, o_rdata;
  logic [7:0] i_ext_rdata = 8'hA5;
  logic o_sfr_sel, o_ram_sel, o_bit_ok, o_ext_sel, o_auto_en;
  int errors = 0;
  int samples_checked = 0;
  always #5 i_mclk = ~i_mclk;
  sps_page_stack u_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_acc(i_acc), .i_direct(i_direct),
    .i_wr(i_wr), .i_bit_op(i_bit_op), .i_bit_sel(i_bit_sel),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_ext_rdata(i_ext_rdata),
    .i_ext_all_pages(i_ext_all_pages), .i_irq_entry(i_irq_entry),
    .i_irq_src(i_irq_src), .i_irq_return(i_irq_return),
    .o_sfr_sel(o_sfr_sel), .o_ram_sel(o_ram_sel), .o_bit_ok(o_bit_ok),
    .o_ext_sel(o_ext_sel), .o_page(o_page), .o_stack_mid(o_stack_mid),
    .o_stack_bot(o_stack_bot), .o_auto_en(o_auto_en), .o_rdata(o_rdata)
  );
  sps_core_model u_core (
    .i_mclk(i_mclk), .o_acc(i_acc), .o_dir(i_direct), .o_wr(i_wr),
    .o_bo(i_bit_op), .o_ad(i_addr), .o_wd(i_wdata), .o_ent(i_irq_entry),
    .o_src(i_irq_src), .o_ret(i_irq_return)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    u_core.put(1'b1, 1'b1, 1'b0, a, d);
    u_core.drop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_core.put(1'b0, 1'b1, 1'b0, a, 8'h00);
    u_core.drop();
    chk(o_rdata, e);
  endtask
  task automatic sk(input logic [7:0] p, m, b);
    chk(o_page, p);
    chk(o_stack_mid, m);
    chk(o_stack_bot, b);
  endtask
  task automatic ext(input logic [7:0] a, input logic e);
    u_core.put(1'b0, 1'b1, 1'b0, a, 8'h00);
    #2;
    chk({7'h00, o_ext_sel}, {7'h00, e});
    u_core.drop();
  endtask
  task automatic t_decode();
    logic [39:0] tab = 40'h7F_8088_FF90;
    logic [7:0] a;
    logic s;
    sk(SPS_RST_PAGE, SPS_RST_MID, SPS_RST_BOT);
    chk({7'h00, o_auto_en}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      a = tab[39-8*i -: 8];
      s = a[7] && (i != 4);
      u_core.put(1'b0, i != 4, 1'b0, a, 8'h00);
      #2;
      chk({7'h00, o_sfr_sel}, {7'h00, s});
      chk({7'h00, o_ram_sel}, {7'h00, !s});
      chk({7'h00, o_bit_ok}, {7'h00, a[2:0] == 3'h0});
      u_core.drop();
    end
    u_core.put(1'b1, 1'b1, 1'b1, SPS_ADDR_MID, 8'h01);
    u_core.drop();
    rd(SPS_ADDR_MID, 8'h00);
  endtask
  task automatic t_stack();
    logic [7:0] ep;
    wrr(SPS_ADDR_MID, 8'h33);
    wrr(SPS_ADDR_BOT, 8'h55);
    u_core.irq(1'b1, 1'b0, SPS_SRC_BUS_CTRL);
    sk(8'h0C, 8'h00, 8'h33);
    // entry and return together: entry wins
    u_core.irq(1'b1, 1'b1, SPS_SRC_SERIAL2);
    sk(8'h10, 8'h0C, 8'h00);
    wrr(SPS_ADDR_BOT, 8'h0F);
    rd(SPS_ADDR_BOT, 8'h0F);
    u_core.irq(1'b0, 1'b1, 4'h0);
    sk(8'h0C, 8'h0F, 8'h00);
    u_core.irq(1'b0, 1'b1, 4'h0);
    sk(8'h0F, 8'h00, 8'h00);
    for (int s = 0; s < 8; s++) begin
      u_core.irq(1'b1, 1'b0, 4'(s));
      ep = (s == 1) ? 8'h0C : (s > 1 && s < 7) ? 8'h10 : 8'h00;
      chk(o_page, ep);
      u_core.irq(1'b0, 1'b1, 4'h0);
    end
  endtask
  task automatic t_alter();
    wrr(SPS_ADDR_PAGE, 8'h0C);
    u_core.irq(1'b1, 1'b0, 4'h0);
    wrr(SPS_ADDR_MID, 8'h0F);
    sk(8'h00, 8'h0F, 8'h00);
    wrr(SPS_ADDR_PAGE, 8'hFF);
    rd(SPS_ADDR_PAGE, 8'hFF);
    u_core.irq(1'b0, 1'b1, 4'h0);
    chk(o_page, 8'h0F);
  endtask
  task automatic t_auto();
    wrr(SPS_ADDR_PAGE, 8'h00);
    wrr(SPS_ADDR_CTRL, 8'h00);
    chk({7'h00, o_auto_en}, 8'h01);
    wrr(SPS_ADDR_PAGE, SPS_PAGE_CTRL);
    wrr(SPS_ADDR_CTRL, 8'hFE);
    rd(SPS_ADDR_CTRL, 8'h00);
    u_core.irq(1'b1, 1'b0, SPS_SRC_BUS_CTRL);
    sk(8'h0F, 8'h00, 8'h00);
    u_core.irq(1'b0, 1'b1, 4'h0);
    sk(8'h0F, 8'h00, 8'h00);
    wrr(SPS_ADDR_CTRL, 8'hFF);
    rd(SPS_ADDR_CTRL, 8'h01);
  endtask
  task automatic t_ext();
    wrr(SPS_ADDR_PAGE, 8'h22);
    ext(8'h90, 1'b0);
    chk(o_rdata, 8'hA5);
    i_ext_all_pages = 1'b1;
    ext(8'h90, 1'b1);
    i_ext_all_pages = 1'b0;
    wrr(SPS_ADDR_PAGE, SPS_PAGE_C);
    ext(8'h90, 1'b1);
    ext(SPS_ADDR_PAGE, 1'b0);
    // indirect access to an own address must not reach the register
    u_core.put(1'b1, 1'b0, 1'b0, SPS_ADDR_PAGE, 8'h55);
    u_core.drop();
    chk(o_page, 8'h0C);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge i_mclk);
    i_rst = 1'b0;
    t_decode();
    t_stack();
    t_alter();
    t_auto();
    t_ext();
    tally_and_finish();
  end
endmodule // sps_page_stack_tb_top
`default_nettype wire
